/* src/pmcg_regs.svh */
// Purpose: Constants for the program memory code guard.
// Assumes: Byte addresses on a 22-bit table address space.
// Notes: Guard bits are active low; erased state is all ones.
`ifndef PMCG_REGS_SVH
`define PMCG_REGS_SVH

// ==========================================================
// Guard word addresses
`define PMCG_ADDR_W 22
`define PMCG_BLOCK_READ_GUARD_BITS 22'h300008
`define PMCG_EEPROM_BOOT_READ_GUARD_BITS 22'h300009
`define PMCG_BLOCK_WRITE_GUARD_BITS 22'h30000A
`define PMCG_EEPROM_BOOT_CONFIG_WRITE_GUARD_BITS 22'h30000B
`define PMCG_BLOCK_TABLE_READ_GUARD_BITS 22'h30000C
`define PMCG_BOOT_TABLE_READ_GUARD_BITS 22'h30000D

// ==========================================================
// Address windows
`define PMCG_CONFIG_BASE 22'h300000
`define PMCG_CONFIG_LAST 22'h30000F
`define PMCG_USER_ID_BASE 22'h200000
`define PMCG_USER_ID_LAST 22'h200007
`define PMCG_DEVICE_ID_BASE 22'h3FFFFE
`define PMCG_DEVICE_ID_LAST 22'h3FFFFF

// ==========================================================
// Field positions
`define PMCG_EEPROM_PROG_BIT 7
`define PMCG_BOOT_PROG_BIT 6
`define PMCG_EEPROM_WR_BIT 7
`define PMCG_BOOT_WR_BIT 6
`define PMCG_CONFIG_WR_BIT 5
`define PMCG_BOOT_XRD_BIT 6

// ==========================================================
// Reset and mask values
`define PMCG_ERASED 8'hFF
`define PMCG_MASK_SMALL 8'h0F
`define PMCG_MASK_LARGE 8'hFF
`define PMCG_MASK_H_PROG 8'hC0
`define PMCG_MASK_H_WR 8'hE0
`define PMCG_MASK_H_XRD 8'h40
`define PMCG_ZERO_BYTE 8'h00

`endif

/* src/pmcg_pkg.sv */
// Purpose: Types for the program memory code guard.
// Assumes: Used with pmcg_regs.svh.
// Notes: Region names the target of one table access.
package pmcg_pkg;
  typedef enum logic [2:0] {
    PMCG_RGN_BOOT,
    PMCG_RGN_BLOCK,
    PMCG_RGN_CONFIG,
    PMCG_RGN_USER_ID,
    PMCG_RGN_DEVICE_ID,
    PMCG_RGN_NONE
  } pmcg_region_e;
endpackage

/* src/pmcg_locator.sv */
// Purpose: Map a byte address to a protection block.
// Assumes: Boot block from 0, binary blocks above it.
// Notes: Combinational; used for target, executing and programmer address.
`timescale 1ns/1ps
`include "pmcg_regs.svh"
module pmcg_locator import pmcg_pkg::*; #(
  parameter int BOOT_BYTES = 2048,
  parameter int BLOCK_BYTES = 16384,
  parameter int NUM_BLOCKS = 8
) (
  // Address in
  input wire logic [`PMCG_ADDR_W-1:0] addr,
  // Result
  output logic in_boot,
  output logic in_user,
  output logic [2:0] block_idx
);
  localparam int USER_LIMIT = BLOCK_BYTES * NUM_BLOCKS;

  // ==========================================================
  // Decode
  always_comb begin
    in_boot = (32'(addr) < BOOT_BYTES); // [R2]
    in_user = (32'(addr) < USER_LIMIT); // [R1]
    block_idx = 3'(32'(addr) / BLOCK_BYTES); // [R2]
  end
endmodule

/* src/pmcg_guard.sv */
// Notes on behaviour
// [R1] Four blocks small part, eight largest part
// [R2] Boot block 1 or 2 Kbytes, binary blocks
// [R3] Each block: programmer, write, cross-read guards
// [R4] Programmer guard blocks only programmer access
// [R5] Write guard zero rejects every table write
// [R6] Read guard zero: same-block reads still work
// [R7] Read guard zero: outside reads return zeros
// [R8] Guard bits only clear; erase restores ones
// [R9] Erase started only by external programmer
// [R10] EEPROM programmer guard blocks programmer access
// [R11] EEPROM write guard blocks all writes
// [R12] CPU always reads data EEPROM
// [R13] Config write guard: programmer-only, protects config
// [R14] CPU table access to config words
// [R15] Device ID readable by table reads
// [R16] Eight user ID locations read and write
// [R17] User ID reads ignore code protection
// [R18] Blocks 4-7 guards only on large part
// [R19] Boot guards mean same as block guards
// [R20] Refused write unchanged, no error shown
//
// Purpose: Guard table and programmer access to program memory.
// Assumes: One access per cycle; memory answers in the cycle of its strobe.
// Notes: Guard bits are active low, held in the six guard words.
`timescale 1ns/1ps
`include "pmcg_regs.svh"
module pmcg_guard import pmcg_pkg::*; #(
  parameter bit LARGE_PART = 1'b1,
  parameter int BOOT_BYTES = 2048,
  parameter int BLOCK_BYTES = 16384
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // CPU table access
  input wire logic tbl_rd,
  input wire logic tbl_wr,
  input wire logic [`PMCG_ADDR_W-1:0] tbl_addr,
  input wire logic [`PMCG_ADDR_W-1:0] exec_addr,
  input wire logic [7:0] tbl_wdata,
  output logic [7:0] tbl_rdata,
  output logic tbl_rvalid,
  // CPU data EEPROM access
  input wire logic ee_cpu_rd,
  input wire logic ee_cpu_wr,
  // External programmer access
  input wire logic prog_mode,
  input wire logic prog_rd,
  input wire logic prog_wr,
  input wire logic prog_ee,
  input wire logic [`PMCG_ADDR_W-1:0] prog_addr,
  input wire logic [7:0] prog_wdata,
  input wire logic prog_chip_erase,
  input wire logic prog_block_erase,
  output logic prog_allow,
  // Memory array side
  input wire logic [7:0] mem_rdata,
  output logic mem_rd,
  output logic mem_wr,
  output logic [`PMCG_ADDR_W-1:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic ee_rd,
  output logic ee_wr
);
  localparam int NUM_BLOCKS = LARGE_PART ? 8 : 4;
  localparam logic [7:0] BLK_MASK =
    LARGE_PART ? `PMCG_MASK_LARGE : `PMCG_MASK_SMALL;

  // Guard words: [0] prog, [1] prog-hi, [2] wr, [3] wr-hi,
  // [4] xread, [5] xread-hi
  logic [7:0] guard [6]; // [R3]
  logic [7:0] next_guard [6];
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic rvalid, next_rvalid, sel_mem, next_sel_mem;
  logic m_rd, m_wr, e_rd, e_wr, allow;
  logic next_m_rd, next_m_wr, next_e_rd, next_e_wr, next_allow;
  logic [`PMCG_ADDR_W-1:0] m_addr, next_m_addr;
  logic [7:0] m_wdata, next_m_wdata;

  // ==========================================================
  // Block location of target, executing code, programmer
  logic t_boot, t_user, x_boot, x_user, p_boot, p_user;
  logic [2:0] t_idx, x_idx, p_idx;

  pmcg_locator #(.BOOT_BYTES(BOOT_BYTES), .BLOCK_BYTES(BLOCK_BYTES),
    .NUM_BLOCKS(NUM_BLOCKS)) u_loc_t (
    .addr(tbl_addr), .in_boot(t_boot), .in_user(t_user),
    .block_idx(t_idx));
  pmcg_locator #(.BOOT_BYTES(BOOT_BYTES), .BLOCK_BYTES(BLOCK_BYTES),
    .NUM_BLOCKS(NUM_BLOCKS)) u_loc_x (
    .addr(exec_addr), .in_boot(x_boot), .in_user(x_user),
    .block_idx(x_idx));
  pmcg_locator #(.BOOT_BYTES(BOOT_BYTES), .BLOCK_BYTES(BLOCK_BYTES),
    .NUM_BLOCKS(NUM_BLOCKS)) u_loc_p (
    .addr(prog_addr), .in_boot(p_boot), .in_user(p_user),
    .block_idx(p_idx));

  function automatic pmcg_region_e region(input logic [21:0] a,
                                          input logic bt,
                                          input logic us);
    pmcg_region_e r;
    r = PMCG_RGN_NONE;
    if (bt) begin
      r = PMCG_RGN_BOOT;
    end else if (us) begin
      r = PMCG_RGN_BLOCK;
    end else if (a >= `PMCG_CONFIG_BASE && a <= `PMCG_CONFIG_LAST) begin
      r = PMCG_RGN_CONFIG;
    end else if (a >= `PMCG_USER_ID_BASE &&
                 a <= `PMCG_USER_ID_LAST) begin
      r = PMCG_RGN_USER_ID;
    end else if (a >= `PMCG_DEVICE_ID_BASE &&
                 a <= `PMCG_DEVICE_ID_LAST) begin
      r = PMCG_RGN_DEVICE_ID;
    end
    return r;
  endfunction

  function automatic logic [7:0] impl_mask(input int i);
    logic [7:0] m;
    case (i)
      0, 2, 4: m = BLK_MASK; // [R18]
      1: m = `PMCG_MASK_H_PROG;
      3: m = `PMCG_MASK_H_WR;
      5: m = `PMCG_MASK_H_XRD;
      default: m = `PMCG_ZERO_BYTE;
    endcase
    return m;
  endfunction

  pmcg_region_e t_rgn, p_rgn;
  logic cfg_locked, t_wr_ok, t_rd_ok, p_ok;
  logic [3:0] gidx;

  // ==========================================================
  // Access decisions
  always_comb begin
    t_rgn = region(tbl_addr, t_boot, t_user);
    p_rgn = region(prog_addr, p_boot, p_user);
    cfg_locked = !guard[3][`PMCG_CONFIG_WR_BIT]; // [R13]
    // Offset from the first guard word; 0 to 5 name guard words
    gidx = 4'(tbl_addr - `PMCG_BLOCK_READ_GUARD_BITS);
    // Table writes: boot, block and config have own write guards; user ID always, device ID never
    case (t_rgn)
      PMCG_RGN_BOOT: t_wr_ok = guard[3][`PMCG_BOOT_WR_BIT]; // [R19]
      PMCG_RGN_BLOCK: t_wr_ok = guard[2][t_idx]; // [R5]
      PMCG_RGN_CONFIG: t_wr_ok = !cfg_locked; // [R14]
      PMCG_RGN_USER_ID: t_wr_ok = 1'b1; // [R16]
      default: t_wr_ok = 1'b0;
    endcase
    // Table reads: cross-read guard applies only from outside
    case (t_rgn)
      PMCG_RGN_BOOT:
        t_rd_ok = guard[5][`PMCG_BOOT_XRD_BIT] || x_boot; // [R19]
      PMCG_RGN_BLOCK:
        t_rd_ok = guard[4][t_idx] ||
                  (x_user && !x_boot && x_idx == t_idx); // [R6] [R7]
      PMCG_RGN_CONFIG, PMCG_RGN_DEVICE_ID: t_rd_ok = 1'b1; // [R14] [R15]
      PMCG_RGN_USER_ID: t_rd_ok = 1'b1; // [R17]
      default: t_rd_ok = 1'b0;
    endcase
    // Programmer access; execution is never gated by these bits
    if (prog_ee) begin
      p_ok = guard[1][`PMCG_EEPROM_PROG_BIT] &&
             (!prog_wr || guard[3][`PMCG_EEPROM_WR_BIT]); // [R10] [R11]
    end else begin
      case (p_rgn)
        PMCG_RGN_BOOT: p_ok = guard[1][`PMCG_BOOT_PROG_BIT]; // [R19]
        PMCG_RGN_BLOCK: p_ok = guard[0][p_idx]; // [R4]
        PMCG_RGN_CONFIG: p_ok = 1'b1; // [R13]
        PMCG_RGN_USER_ID, PMCG_RGN_DEVICE_ID: p_ok = 1'b1; // [R16]
        default: p_ok = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Guard words: clear-only writes, erase restores ones
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      next_guard[i] = guard[i];
    end
    if (prog_mode && prog_chip_erase) begin
      for (int i = 0; i < 6; i++) begin
        next_guard[i] = impl_mask(i); // [R8] [R9]
      end
    end else if (prog_mode && prog_block_erase) begin
      // Block erase restores the guards of the addressed block
      if (p_rgn == PMCG_RGN_BOOT) begin
        next_guard[1][`PMCG_BOOT_PROG_BIT] = 1'b1; // [R8] [R9]
        next_guard[3][`PMCG_BOOT_WR_BIT] = 1'b1;
        next_guard[5][`PMCG_BOOT_XRD_BIT] = 1'b1;
      end else if (p_rgn == PMCG_RGN_BLOCK) begin
        next_guard[0][p_idx] = 1'b1; // [R8] [R9]
        next_guard[2][p_idx] = 1'b1;
        next_guard[4][p_idx] = 1'b1;
      end
    end else if (prog_mode && prog_wr && !prog_ee &&
                 p_rgn == PMCG_RGN_CONFIG &&
                 prog_addr >= `PMCG_BLOCK_READ_GUARD_BITS &&
                 prog_addr <= `PMCG_BOOT_TABLE_READ_GUARD_BITS) begin
      // Programmer may clear the config write guard as well
      for (int i = 0; i < 6; i++) begin
        if (4'(prog_addr - `PMCG_BLOCK_READ_GUARD_BITS) == 4'(i)) begin
          next_guard[i] = guard[i] & (prog_wdata | ~impl_mask(i)); // [R8]
        end
      end
    end else if (!prog_mode && tbl_wr && t_rgn == PMCG_RGN_CONFIG &&
                 !cfg_locked) begin
      for (int i = 0; i < 6; i++) begin
        if (gidx == 4'(i)) begin
          next_guard[i] = guard[i] & (tbl_wdata | ~impl_mask(i)); // [R8]
          if (i == 3) begin
            // The CPU cannot move the config write guard itself
            next_guard[i][`PMCG_CONFIG_WR_BIT] =
              guard[i][`PMCG_CONFIG_WR_BIT]; // [R13]
          end
        end
      end
    end
  end

  // ==========================================================
  // Memory strobes and read data
  always_comb begin
    next_m_rd = 1'b0;
    next_m_wr = 1'b0;
    next_m_addr = m_addr;
    next_m_wdata = m_wdata;
    next_e_rd = 1'b0;
    next_e_wr = 1'b0;
    next_allow = 1'b0;
    next_rvalid = 1'b0;
    next_sel_mem = 1'b0;
    next_rdata = rdata;
    if (prog_mode) begin
      next_allow = (prog_rd || prog_wr) && p_ok; // [R4] [R10]
      next_m_rd = prog_rd && p_ok && !prog_ee;
      next_m_wr = prog_wr && p_ok && !prog_ee;
      next_e_rd = prog_rd && p_ok && prog_ee;
      next_e_wr = prog_wr && p_ok && prog_ee; // [R11]
      next_m_addr = prog_addr;
      next_m_wdata = prog_wdata;
    end else begin
      if (tbl_wr) begin
        // Refused writes simply drop out, with no flag raised
        next_m_wr = t_wr_ok; // [R5] [R20]
        next_m_addr = tbl_addr;
        next_m_wdata = tbl_wdata;
      end else if (tbl_rd) begin
        next_m_rd = t_rd_ok;
        next_m_addr = tbl_addr;
        next_rvalid = 1'b1;
        next_sel_mem = t_rd_ok;
        next_rdata = `PMCG_ZERO_BYTE; // [R7]
        // Guard words are held here, the array copy may be stale
        for (int i = 0; i < 6; i++) begin
          if (t_rgn == PMCG_RGN_CONFIG && gidx == 4'(i)) begin
            next_sel_mem = 1'b0;
            next_rdata = guard[i]; // [R14]
          end
        end
      end
      next_e_rd = ee_cpu_rd; // [R12]
      next_e_wr = ee_cpu_wr && guard[3][`PMCG_EEPROM_WR_BIT]; // [R11]
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // Erased state, unimplemented bits held at zero
      guard[0] <= BLK_MASK;
      guard[1] <= `PMCG_MASK_H_PROG;
      guard[2] <= BLK_MASK;
      guard[3] <= `PMCG_MASK_H_WR;
      guard[4] <= BLK_MASK;
      guard[5] <= `PMCG_MASK_H_XRD;
      m_rd <= 1'b0;
      m_wr <= 1'b0;
      m_addr <= '0;
      m_wdata <= `PMCG_ZERO_BYTE;
      e_rd <= 1'b0;
      e_wr <= 1'b0;
      allow <= 1'b0;
      rvalid <= 1'b0;
      sel_mem <= 1'b0;
      rdata <= `PMCG_ZERO_BYTE;
    end else begin
      for (int i = 0; i < 6; i++) begin
        guard[i] <= next_guard[i] & impl_mask(i);
      end
      m_rd <= next_m_rd;
      m_wr <= next_m_wr;
      m_addr <= next_m_addr;
      m_wdata <= next_m_wdata;
      e_rd <= next_e_rd;
      e_wr <= next_e_wr;
      allow <= next_allow;
      rvalid <= next_rvalid;
      sel_mem <= next_sel_mem;
      rdata <= next_rdata;
    end
  end

  // Second stage so read data is registered as well
  logic [7:0] out_data;
  logic out_valid;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_data <= `PMCG_ZERO_BYTE;
      out_valid <= 1'b0;
    end else begin
      out_data <= sel_mem ? mem_rdata : rdata; // [R6] [R7]
      out_valid <= rvalid;
    end
  end

  assign tbl_rdata = out_data;
  assign tbl_rvalid = out_valid;
  assign mem_rd = m_rd;
  assign mem_wr = m_wr;
  assign mem_addr = m_addr;
  assign mem_wdata = m_wdata;
  assign ee_rd = e_rd;
  assign ee_wr = e_wr;
  assign prog_allow = allow;
endmodule

/* sim/pmcg_mem_model.sv */
// Purpose: Program array model behind the code guard.
// Assumes: Unwritten bytes hold a value made from the address.
// Notes: Read data stands two cycles after the strobe, then toggles.
`timescale 1ns/1ps
module pmcg_mem_model (
  // Clock
  input wire logic mclk,
  // Array port
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [21:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  // ====
  // Storage
  logic [7:0] arr [int];
  logic [7:0] q = 8'h00;
  logic hv = 1'b0;
  function automatic logic [7:0] rv(input logic [21:0] a);
    return arr.exists(int'(a)) ? arr[int'(a)] : a[7:0] ^ a[15:8];
  endfunction
  // Stale data stands two cycles after a read, then toggles each cycle, so a late sample sees it change
  assign mem_rdata = mem_rd ? rv(mem_addr) : q;
  always @(posedge mclk) begin
    hv <= mem_rd;
    if (mem_rd)
      q <= rv(mem_addr);
    else if (!hv)
      q <= ~q;
    if (mem_wr)
      arr[int'(mem_addr)] = mem_wdata;
  end
endmodule

/* sim/pmcg_guard_asserts.sv */
// Purpose: Port checks of the code guard.
// Assumes: Strobes are one-cycle pulses.
// Notes: Guard state is internal; only causes and answers are checked.
`timescale 1ns/1ps
`include "pmcg_regs.svh"
module pmcg_guard_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Table side
  input wire logic tbl_rd,
  input wire logic tbl_wr,
  input wire logic [`PMCG_ADDR_W-1:0] tbl_addr,
  input wire logic [`PMCG_ADDR_W-1:0] exec_addr,
  input wire logic [7:0] tbl_wdata,
  input wire logic [7:0] tbl_rdata,
  input wire logic tbl_rvalid,
  input wire logic ee_cpu_rd,
  input wire logic ee_cpu_wr,
  // Programmer side
  input wire logic prog_mode,
  input wire logic prog_rd,
  input wire logic prog_wr,
  input wire logic prog_ee,
  input wire logic prog_chip_erase,
  input wire logic prog_allow,
  // Array side
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [`PMCG_ADDR_W-1:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic ee_rd,
  input wire logic ee_wr
);
  // ====
  // Checks
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire logic trq = tbl_rd && !tbl_wr && !prog_mode;
  wire logic twq = tbl_wr && !prog_mode;
  read_answer_a: assert property (trq |-> ##2 tbl_rvalid)
    else $error("table read not answered");
  rvalid_cause_a: assert property (tbl_rvalid |-> $past(trq, 2))
    else $error("read answer without request");
  same_block_a: assert property (
    trq && tbl_addr == exec_addr |=>
    mem_rd && mem_addr == $past(tbl_addr))
    else $error("same block read refused");
  refused_zero_a: assert property (
    tbl_rvalid && !$past(mem_rd) |-> tbl_rdata == 8'h00)
    else $error("refused read not zero");
  user_id_a: assert property (
    trq && tbl_addr >= `PMCG_USER_ID_BASE &&
    tbl_addr <= `PMCG_USER_ID_LAST |=> mem_rd)
    else $error("user id read refused");
  write_cause_a: assert property (
    mem_wr |-> $past(twq || (prog_mode && prog_wr)))
    else $error("array write without request");
  write_data_a: assert property (
    mem_wr && $past(twq) |->
    mem_wdata == $past(tbl_wdata) && mem_addr == $past(tbl_addr))
    else $error("array write data wrong");
  ee_read_a: assert property (ee_cpu_rd && !prog_mode |=> ee_rd)
    else $error("cpu eeprom read refused");
  ee_write_cause_a: assert property (
    ee_wr |-> $past(ee_cpu_wr || (prog_mode && prog_wr && prog_ee)))
    else $error("eeprom write without request");
  allow_cause_a: assert property (
    prog_allow |->
    $past(prog_mode && (prog_rd || prog_wr || prog_chip_erase)))
    else $error("grant without programmer request");
endmodule
bind pmcg_guard pmcg_guard_asserts pmcg_guard_asserts_i (.*);

/* sim/tb_pmcg_guard.sv */
// Purpose: Self-checking bench of the code guard.
// Assumes: Large part, default block sizes.
// Notes: Waits for answers under a bound, since latency is edge-based.
`timescale 1ns/1ps
`include "pmcg_regs.svh"
module tb_pmcg_guard;
  logic mclk = 0, rst_n = 0, tbl_rd = 0, tbl_wr = 0;
  logic ee_cpu_rd = 0, ee_cpu_wr = 0, prog_mode = 0, prog_rd = 0;
  logic prog_wr = 0, prog_ee = 0, prog_chip_erase = 0, prog_block_erase = 0;
  logic [21:0] tbl_addr = 0, exec_addr = 0, prog_addr = 0, mem_addr, a;
  logic [7:0] tbl_wdata = 0, prog_wdata = 0, tbl_rdata, mem_rdata;
  logic [7:0] mem_wdata;
  logic tbl_rvalid, prog_allow, mem_rd, mem_wr, ee_rd, ee_wr;
  int fail_count = 0, compares = 0, cyc = 0, ee_n = 0, al_n = 0;
  logic [7:0] rv [6] = '{8'hFF, 8'hC0, 8'hFF, 8'hE0, 8'hFF, 8'h40};
  pmcg_guard pmcg_guard_i (.*);
  pmcg_mem_model pmcg_mem_model_i (.*);
  initial forever #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    // Outputs are unknown before the first reset edge
    if (rst_n) begin
      ee_n <= ee_n + ee_rd + ee_wr;
      al_n <= al_n + prog_allow;
    end
    if (cyc == 5000) begin
      fail_count++;
      final_report;
    end
  end
  // ====
  // Tasks
  function automatic logic [7:0] dv(input logic [21:0] x);
    return x[7:0] ^ x[15:8];
  endfunction
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("fails %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task rd(input logic [21:0] t, x, input logic [7:0] e);
    logic [7:0] q;
    q = 8'hXX;
    tbl_addr = t;
    exec_addr = x;
    tbl_rd = 1;
    @(negedge mclk) tbl_rd = 0;
    repeat (4) begin
      @(negedge mclk);
      if (tbl_rvalid === 1'b1)
        q = tbl_rdata;
    end
    chk(q, e);
  endtask
  task wr(input logic [21:0] t, input logic [7:0] v);
    tbl_addr = t;
    exec_addr = '0;
    tbl_wdata = v;
    tbl_wr = 1;
    @(negedge mclk) tbl_wr = 0;
    @(negedge mclk);
  endtask
  task ee(input logic r, w, input logic [7:0] e);
    int n0;
    n0 = ee_n;
    ee_cpu_rd = r;
    ee_cpu_wr = w;
    @(negedge mclk);
    ee_cpu_rd = 0;
    ee_cpu_wr = 0;
    repeat (3) @(negedge mclk);
    chk(8'(ee_n - n0), e);
  endtask
  task pm(input logic r, w, e, input logic [21:0] t,
          input logic [7:0] v, x);
    int n0;
    n0 = al_n;
    {prog_rd, prog_wr, prog_ee, prog_addr, prog_wdata} = {r, w, e, t, v};
    @(negedge mclk);
    prog_rd = 0;
    prog_wr = 0;
    repeat (3) @(negedge mclk);
    chk(8'(al_n - n0), x);
  endtask
  task erase(input logic b, input logic [21:0] t);
    prog_mode = 1;
    prog_addr = t;
    @(negedge mclk) {prog_block_erase, prog_chip_erase} = {b, !b};
    @(negedge mclk) {prog_block_erase, prog_chip_erase} = 2'b00;
    repeat (2) @(negedge mclk);
    prog_mode = 0;
    @(negedge mclk);
  endtask
  // ====
  // Scenarios
  initial begin
    void'($urandom(35079));
    repeat (4) @(negedge mclk);
    rst_n = 1;
    for (int i = 0; i < 6; i++)
      rd(22'h300008 + 22'(i), '0, rv[i]);
    repeat (16) begin
      a = 22'($urandom % 32'h20000);
      rd(a, 22'($urandom % 32'h20000), dv(a));
    end
    wr(22'h30000B, 8'hDF);
    rd(22'h30000B, '0, 8'hE0);
    wr(22'h30000C, 8'h7D);
    wr(22'h30000C, 8'hFF);
    rd(22'h30000C, '0, 8'h7D);
    rd(22'h004010, 22'h008000, 8'h00);
    rd(22'h004010, 22'h004020, dv(22'h004010));
    rd(22'h004010, 22'h004010, dv(22'h004010));
    rd(22'h01C004, '0, 8'h00);
    wr(22'h30000D, 8'h00);
    rd(22'h000010, 22'h008000, 8'h00);
    rd(22'h3FFFFE, 22'h008000, dv(22'h3FFFFE));
    wr(22'h30000A, 8'hFB);
    wr(22'h008004, 8'h5A);
    rd(22'h008004, 22'h008000, dv(22'h008004));
    wr(22'h00C004, 8'hA5);
    rd(22'h00C004, 22'h00C000, 8'hA5);
    wr(22'h200007, 8'h3C);
    rd(22'h200007, 22'h008000, 8'h3C);
    wr(22'h300001, 8'h96);
    rd(22'h300001, 22'h008000, 8'h96);
    ee(0, 1, 8'h01);
    wr(22'h30000B, 8'h7F);
    ee(0, 1, 8'h00);
    ee(1, 0, 8'h01);
    rd(22'h30000B, '0, 8'h60);
    prog_mode = 1;
    @(negedge mclk);
    pm(1, 0, 0, 22'h000900, 8'h00, 8'h01);
    pm(0, 1, 0, 22'h300008, 8'hFE, 8'h01);
    pm(1, 0, 0, 22'h000900, 8'h00, 8'h00);
    pm(1, 0, 1, 22'h000010, 8'h00, 8'h01);
    pm(0, 1, 1, 22'h000010, 8'h11, 8'h00);
    pm(0, 1, 0, 22'h300009, 8'h7F, 8'h01);
    pm(1, 0, 1, 22'h000010, 8'h00, 8'h00);
    pm(0, 1, 0, 22'h30000B, 8'hDF, 8'h01);
    prog_mode = 0;
    @(negedge mclk);
    rd(22'h30000B, '0, 8'h40);
    wr(22'h300001, 8'h00);
    rd(22'h300001, '0, 8'h96);
    // Block erase restores only the guards of the addressed block
    erase(1'b1, 22'h004000);
    rd(22'h30000C, '0, 8'h7F);
    rd(22'h300008, '0, 8'hFE);
    erase(1'b1, 22'h000010);
    rd(22'h30000D, '0, 8'h40);
    erase(1'b0, '0);
    for (int i = 0; i < 6; i++)
      rd(22'h300008 + 22'(i), '0, rv[i]);
    final_report;
  end
endmodule
